// [hdl/sbmc_pkg.sv]
// sbmc_pkg: constants for the burst and latency configuration block.
// assumes one device clock; shared by the top module and the address sequencer.
package sbmc_pkg;
  localparam logic [7:0] MA_BURST_CFG = 8'h01;
  localparam logic [7:0] MA_LAT_CFG = 8'h02;
  localparam int BL_LSB = 0;
  localparam int BT_BIT = 3;
  localparam int WC_BIT = 4;
  localparam int NWR_LSB = 5;
  localparam int LAT_LSB = 0;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] BL_CODE_16 = 3'h4;
  localparam logic [2:0] NWR_CODE_MIN = 3'h1;
  localparam logic [2:0] NWR_CODE_MAX = 3'h6;
  localparam logic [3:0] LAT_CODE_MIN = 4'h1;
  localparam logic [3:0] LAT_CODE_MAX = 4'h6;
  // reset values: length 4, sequential, wrap, recovery 3, latency 3/1
  localparam logic [7:0] BURST_CFG_RESET = 8'h22;
  localparam logic [7:0] LAT_CFG_RESET = 8'h01;
  // decoded output values while reset holds, matching the two reset settings above
  localparam logic [3:0] RL_RESET = 4'h3;
  localparam logic [2:0] WL_RESET = 3'h1;
  localparam logic [3:0] NWR_RESET = 4'h3;
  localparam logic [4:0] BL_BEATS_RESET = 5'h04;
  localparam logic [3:0] NWR_BASE = 4'h2;
  localparam int COL_W = 10;
  typedef enum logic [1:0] {SBMC_LEN4, SBMC_LEN8, SBMC_LEN16} sbmc_len_t;
endpackage

// [hdl/sbmc_seq.sv]
// sbmc_seq: column order generator for one burst.
// assumes length and mode are held stable while busy; the start column is captured at start.
`timescale 1ns/100ps
module sbmc_seq (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic [9:0] col_in,
  input wire sbmc_pkg::sbmc_len_t len_in,
  input wire logic interleave_in,
  input wire logic no_wrap_in,
  output logic [9:0] col_out,
  output logic valid_out,
  output logic last_out
);
  logic [3:0] beat_q;
  logic [3:0] beat_d;
  logic busy_q;
  logic [9:0] base_q;
  logic [3:0] mask;
  logic [3:0] off;
  logic [3:0] seq_low;
  logic [3:0] int_low;
  logic [3:0] low;
  logic [9:0] col_d;
  logic last_beat;
  assign mask = (len_in == sbmc_pkg::SBMC_LEN16) ? 4'hF :
                (len_in == sbmc_pkg::SBMC_LEN8) ? 4'h7 : 4'h3;
  assign off = start_in ? 4'h0 : beat_d;
  assign seq_low = (base_q[3:0] + off) & mask;
  assign int_low = (base_q[3:0] ^ off) & mask;
  assign low = interleave_in && len_in == sbmc_pkg::SBMC_LEN8 ? int_low : seq_low;
  assign beat_d = beat_q + 4'h1;
  assign last_beat = (beat_d & mask) == mask;
  always_comb
  begin
    if (start_in)
      col_d = {col_in[9:1], 1'b0};
    else if (no_wrap_in)
      col_d = base_q + {6'h0, beat_d};
    else
      col_d = {base_q[9:4], (base_q[3:0] & ~mask) | low};
  end
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      beat_q <= 4'h0;
      busy_q <= 1'b0;
      base_q <= 10'h000;
      col_out <= 10'h000;
      valid_out <= 1'b0;
      last_out <= 1'b0;
    end
    else if (ce_in)
    begin
      valid_out <= start_in || (busy_q && !last_out);
      if (start_in)
      begin
        base_q <= {col_in[9:1], 1'b0};
        beat_q <= 4'h0;
        busy_q <= 1'b1;
        col_out <= col_d;
        last_out <= 1'b0;
      end
      else if (busy_q && !last_out)
      begin
        beat_q <= beat_d;
        col_out <= col_d;
        last_out <= last_beat;
        busy_q <= !last_beat;
      end
      else
      begin
        busy_q <= 1'b0;
        last_out <= 1'b0;
      end
    end
  end
endmodule // sbmc_seq

// [hdl/sbmc_top.sv]
// sbmc_top: burst and latency mode registers with burst column sequencing.
// assumes the controller writes mode registers on the device clock and
// never starts a burst while the previous one is still running.
`timescale 1ns/100ps
module sbmc_top (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic mrw_in,
  input wire logic mrr_in,
  input wire logic [7:0] mode_reg_address_in,
  input wire logic [7:0] mode_reg_data_in,
  input wire logic burst_start_in,
  input wire logic burst_write_in,
  input wire logic auto_precharge_in,
  input wire logic [9:0] col_in,
  output logic [9:0] col_out,
  output logic col_valid_out,
  output logic col_last_out,
  output logic burst_illegal_out,
  output logic precharge_start_out,
  output logic [3:0] read_latency_out,
  output logic [2:0] write_latency_out,
  output logic [3:0] write_recovery_cycles_out,
  output logic [4:0] burst_length_out,
  output logic burst_type_out,
  output logic wrap_control_out,
  output logic [7:0] mrr_data_out,
  output logic mrr_strobe_out
);
  logic [7:0] burst_cfg_q;
  logic [7:0] lat_cfg_q;
  logic [3:0] rec_cnt_q;
  logic rec_busy_q;
  logic ap_pend_q;
  logic [2:0] bl_code;
  logic [2:0] nwr_code;
  logic [3:0] lat_code;
  logic bt;
  logic nw;
  logic bl_ok;
  logic nwr_ok;
  logic lat_ok;
  logic wr_burst;
  logic wr_lat;
  logic illegal;
  logic [3:0] nwr_cycles;
  logic [3:0] rl;
  logic [2:0] wl;
  logic [4:0] bl_beats;
  sbmc_pkg::sbmc_len_t len;
  logic seq_valid;
  logic seq_last;
  logic [9:0] seq_col;
  logic start_ok;
  assign wr_burst = mrw_in && mode_reg_address_in == sbmc_pkg::MA_BURST_CFG;
  assign wr_lat = mrw_in && mode_reg_address_in == sbmc_pkg::MA_LAT_CFG;
  assign bl_code = burst_cfg_q[sbmc_pkg::BL_LSB +: 3];
  assign bt = burst_cfg_q[sbmc_pkg::BT_BIT];
  assign nw = burst_cfg_q[sbmc_pkg::WC_BIT];
  assign nwr_code = burst_cfg_q[sbmc_pkg::NWR_LSB +: 3];
  assign lat_code = lat_cfg_q[sbmc_pkg::LAT_LSB +: 4];
  // reserved codes are refused at write time so the decoded state stays legal
  assign bl_ok = mode_reg_data_in[2:0] == sbmc_pkg::BL_CODE_4 ||
                 mode_reg_data_in[2:0] == sbmc_pkg::BL_CODE_8 ||
                 mode_reg_data_in[2:0] == sbmc_pkg::BL_CODE_16;
  assign nwr_ok = mode_reg_data_in[7:5] >= sbmc_pkg::NWR_CODE_MIN &&
                  mode_reg_data_in[7:5] <= sbmc_pkg::NWR_CODE_MAX;
  assign lat_ok = mode_reg_data_in[3:0] >= sbmc_pkg::LAT_CODE_MIN &&
                  mode_reg_data_in[3:0] <= sbmc_pkg::LAT_CODE_MAX;
  assign len = bl_code == sbmc_pkg::BL_CODE_16 ? sbmc_pkg::SBMC_LEN16 :
               bl_code == sbmc_pkg::BL_CODE_8 ? sbmc_pkg::SBMC_LEN8 :
               sbmc_pkg::SBMC_LEN4;
  assign bl_beats = len == sbmc_pkg::SBMC_LEN16 ? 5'h10 :
                    len == sbmc_pkg::SBMC_LEN8 ? 5'h08 : 5'h04;
  assign nwr_cycles = {1'b0, nwr_code} + sbmc_pkg::NWR_BASE;
  // length 16 interleaved and any no-wrap above 4 are refused
  assign illegal = (len != sbmc_pkg::SBMC_LEN4 && nw) ||
                   (len == sbmc_pkg::SBMC_LEN16 && bt);
  assign start_ok = burst_start_in && !illegal;
  always_comb
  begin
    case (lat_code)
      4'h1: begin rl = 4'h3; wl = 3'h1; end
      4'h2: begin rl = 4'h4; wl = 3'h2; end
      4'h3: begin rl = 4'h5; wl = 3'h2; end
      4'h4: begin rl = 4'h6; wl = 3'h3; end
      4'h5: begin rl = 4'h7; wl = 3'h4; end
      4'h6: begin rl = 4'h8; wl = 3'h4; end
      default: begin rl = 4'h3; wl = 3'h1; end
    endcase
  end
  sbmc_seq u_seq (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .start_in(start_ok),
    .col_in(col_in),
    .len_in(len),
    .interleave_in(bt),
    .no_wrap_in(nw),
    .col_out(seq_col),
    .valid_out(seq_valid),
    .last_out(seq_last)
  );
  // partial writes with reserved codes are dropped whole, never half applied
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      burst_cfg_q <= sbmc_pkg::BURST_CFG_RESET;
      lat_cfg_q <= sbmc_pkg::LAT_CFG_RESET;
    end
    else if (ce_in)
    begin
      if (wr_burst && bl_ok && nwr_ok)
        burst_cfg_q <= mode_reg_data_in;
      if (wr_lat && lat_ok)
        lat_cfg_q <= {4'h0, mode_reg_data_in[3:0]};
    end
  end

  // column stage costs one cycle so every output leaves a flip-flop
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      col_out <= 10'h000;
      col_valid_out <= 1'b0;
      col_last_out <= 1'b0;
      burst_illegal_out <= 1'b0;
    end
    else if (ce_in)
    begin
      col_out <= seq_col;
      col_valid_out <= seq_valid;
      col_last_out <= seq_last;
      burst_illegal_out <= burst_start_in && illegal;
    end
  end

  // recovery count runs from the last write beat
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      rec_cnt_q <= 4'h0;
      rec_busy_q <= 1'b0;
      ap_pend_q <= 1'b0;
      precharge_start_out <= 1'b0;
    end
    else if (ce_in)
    begin
      if (start_ok)
        ap_pend_q <= burst_write_in && auto_precharge_in;
      precharge_start_out <= 1'b0;
      if (seq_last && ap_pend_q)
      begin
        rec_busy_q <= 1'b1;
        rec_cnt_q <= nwr_cycles;
        ap_pend_q <= 1'b0;
      end
      else if (rec_busy_q)
      begin
        rec_cnt_q <= rec_cnt_q - 4'h1;
        if (rec_cnt_q == 4'h1)
        begin
          rec_busy_q <= 1'b0;
          precharge_start_out <= 1'b1;
        end
      end
    end
  end

  // decoded settings lag the registers by one cycle
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      read_latency_out <= sbmc_pkg::RL_RESET;
      write_latency_out <= sbmc_pkg::WL_RESET;
      write_recovery_cycles_out <= sbmc_pkg::NWR_RESET;
      burst_length_out <= sbmc_pkg::BL_BEATS_RESET;
      burst_type_out <= 1'b0;
      wrap_control_out <= 1'b0;
    end
    else if (ce_in)
    begin
      read_latency_out <= rl;
      write_latency_out <= wl;
      write_recovery_cycles_out <= nwr_cycles;
      burst_length_out <= bl_beats;
      burst_type_out <= bt;
      wrap_control_out <= nw;
    end
  end

  // write-only registers answer with zero data but the strobe still pulses
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      mrr_strobe_out <= 1'b0;
      mrr_data_out <= 8'h00;
    end
    else if (ce_in)
    begin
      mrr_strobe_out <= mrr_in;
      mrr_data_out <= 8'h00;
    end
  end
endmodule // sbmc_top

// [dv/sbmc_top_asserts.sv]
// sbmc_top_asserts: port checks on mode decode and burst column order.
// assumes clock enable held high and config quiet while a burst runs.
`timescale 1ns/100ps
module sbmc_top_asserts (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic mrr_in,
  input wire logic burst_start_in,
  input wire logic [9:0] col_out,
  input wire logic col_valid_out,
  input wire logic col_last_out,
  input wire logic burst_illegal_out,
  input wire logic [3:0] read_latency_out,
  input wire logic [2:0] write_latency_out,
  input wire logic [3:0] write_recovery_cycles_out,
  input wire logic [4:0] burst_length_out,
  input wire logic burst_type_out,
  input wire logic wrap_control_out,
  input wire logic mrr_strobe_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  a_len_legal: assert property (burst_length_out inside {5'h04, 5'h08, 5'h10})
    else $error("burst length not 4, 8 or 16");
  a_rec_range: assert property (write_recovery_cycles_out inside {[4'h3:4'h8]})
    else $error("recovery count out of range");
  a_lat_pair: assert property ({read_latency_out, write_latency_out} inside
    {7'h19, 7'h22, 7'h2A, 7'h33, 7'h3C, 7'h44}) else $error("latency pair not listed");
  a_first_beat: assert property ($rose(col_valid_out) |-> $past(burst_start_in, 2)
    && !col_out[0]) else $error("first beat late or odd");
  a_read_strobe: assert property (mrr_in |=> mrr_strobe_out)
    else $error("no read strobe");
  // refused starts must not leak a single beat
  a_bad_refused: assert property (burst_start_in && ((wrap_control_out &&
    burst_length_out != 5'h04) || (burst_type_out && burst_length_out == 5'h10))
    |=> burst_illegal_out ##1 !col_valid_out) else $error("illegal start not refused");
  a_seq16_step: assert property (col_valid_out && !col_last_out &&
    burst_length_out == 5'h10 |=> col_valid_out && col_out[9:4] == $past(col_out[9:4])
    && col_out[3:0] == $past(col_out[3:0]) + 4'h1) else $error("length 16 order wrong");
  a_nw_step: assert property (col_valid_out && !col_last_out && wrap_control_out
    |=> col_out == $past(col_out) + 10'h001) else $error("no-wrap order wrong");
  cover property (col_last_out && burst_length_out == 5'h10);
  cover property (col_last_out && wrap_control_out);
  cover property (burst_illegal_out);
endmodule // sbmc_top_asserts

// [dv/sbmc_ctrl.sv]
// sbmc_ctrl: controller model for mode and burst requests.
// assumes requests launch 1 ns after a rising edge of mclk_in.
`timescale 1ns/100ps
module sbmc_ctrl (
  input wire logic mclk_in,
  output logic mrw_out,
  output logic mrr_out,
  output logic [7:0] addr_out,
  output logic [7:0] data_out,
  output logic start_out,
  output logic write_out,
  output logic [9:0] col_out
);
  initial
  begin
    {mrw_out, mrr_out, start_out, write_out} = 4'h0;
    {addr_out, data_out, col_out} = 26'h0;
  end
  task automatic mr(input logic [7:0] a, input logic [7:0] d, input logic rd);
    @(posedge mclk_in);
    #1;
    addr_out = a;
    data_out = (a == 8'h02) ? {4'h0, d[3:0]} : d;
    {mrr_out, mrw_out} = {rd, !rd};
    @(posedge mclk_in);
    #1;
    {mrr_out, mrw_out} = 2'h0;
    {addr_out, data_out} = ~{addr_out, data_out};
  endtask
  // starts only from idle; the caller waits out the previous burst
  task automatic burst(input logic [9:0] c, input logic nw, input logic wr, output logic [9:0] u);
    u = (nw && c[8:1] inside {8'hFF, 8'h00}) ? c ^ 10'h004 : c;
    @(posedge mclk_in);
    #1;
    col_out = u;
    write_out = wr;
    start_out = 1'b1;
    @(posedge mclk_in);
    #1;
    start_out = 1'b0;
    col_out = ~u;
  endtask
endmodule // sbmc_ctrl

// [dv/sbmc_top_bench.sv]
// sbmc_top_bench: random and corner tests of mode writes and burst order.
// assumes sbmc_ctrl drives requests; auto-precharge follows the write flag.
`timescale 1ns/100ps
module sbmc_top_bench;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic mrw, mrr, st, wr, vld, lst, ill, pre, typ, nwo, stb;
  logic [7:0] ma, md, rd;
  logic [9:0] ci, co, u;
  logic [3:0] rl, wrc;
  logic [2:0] wl;
  logic [4:0] bl;
  logic [7:0] lat = 8'h31;
  logic [2:0] wlt [8] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h4, 3'h0};
  logic [4:0] cor [9] = '{5'h08, 5'h0A, 5'h09, 5'h0C, 5'h0E, 5'h10, 5'h0D, 5'h12, 5'h11};
  int err_count = 0;
  int check_count = 0;
  always #2.5 mclk_in = ~mclk_in;
  sbmc_ctrl ctrl_u (.mclk_in(mclk_in), .mrw_out(mrw), .mrr_out(mrr), .addr_out(ma),
    .data_out(md), .start_out(st), .write_out(wr), .col_out(ci));
  sbmc_top dut_u (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(1'b1), .mrw_in(mrw), .mrr_in(mrr),
    .mode_reg_address_in(ma), .mode_reg_data_in(md), .burst_start_in(st), .burst_write_in(wr),
    .auto_precharge_in(wr), .col_in(ci), .col_out(co), .col_valid_out(vld), .col_last_out(lst),
    .burst_illegal_out(ill), .precharge_start_out(pre), .read_latency_out(rl),
    .write_latency_out(wl), .write_recovery_cycles_out(wrc), .burst_length_out(bl),
    .burst_type_out(typ), .wrap_control_out(nwo), .mrr_data_out(rd), .mrr_strobe_out(stb));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wt2();
    repeat (2) @(posedge mclk_in);
    #1;
  endtask
  function automatic logic [9:0] ecol(logic [9:0] s, int i, int n, logic il, logic nw);
    logic [9:0] m;
    m = 10'(n - 1);
    if (nw)
      return s + 10'(i);
    if (il && n == 8)
      return s ^ 10'(i);
    return (s & ~m) | ((s + 10'(i)) & m);
  endfunction
  // k packs length code, interleave and no-wrap
  task automatic run(input logic [4:0] k, input logic [2:0] rc, input logic w);
    int n, b, tl, tp;
    logic [15:0] ni;
    logic bad;
    n = 1 << k[4:2];
    bad = (k[0] && n > 4) || (k[1] && n == 16);
    {b, tl, tp} = 96'h0;
    ni = 16'h0;
    ctrl_u.mr(8'h01, {rc, k[0], k[1], k[4:2]}, 1'b0);
    wt2();
    chk({wrc, bl, typ, nwo}, {4'(rc + 2), 5'(n), k[1], k[0]});
    ctrl_u.burst(10'($urandom), k[0], w, u);
    // the refusal pulse stands only in the cycle right after the start edge
    ni = 16'(ill);
    for (int t = 0; t < 40; t++)
    begin
      @(posedge mclk_in);
      #1;
      if (vld === 1'b1)
      begin
        chk(co, ecol({u[9:1], 1'b0}, b, n, k[1], k[0]));
        chk(lst, b == n - 1);
        tl = t;
        b++;
      end
      ni += ill;
      if (pre === 1'b1)
        tp = t;
    end
    chk(b, bad ? 0 : n);
    chk(ni, bad);
    if (w && !bad)
      chk(tp - tl, rc + 2);
  endtask
  initial
  begin
    void'($urandom(11));
    repeat (4) @(posedge mclk_in);
    #1;
    rst_in = 1'b0;
    chk({rl, wl, wrc, bl}, {4'h3, 3'h1, 4'h3, 5'h04});
    chk({typ, nwo, ill, vld}, 4'h0);
    $display("test reset done");
    for (int c = 0; c < 8; c++)
    begin
      ctrl_u.mr(8'h02, 8'(c), 1'b0);
      wt2();
      if (c > 0 && c < 7)
        lat = {4'(c + 2), 1'b0, wlt[c]};
      chk({rl, 1'b0, wl}, lat);
    end
    $display("test latency done");
    for (int j = 0; j < 30; j++)
      run(j < 9 ? cor[j] : {3'(2 + $urandom % 3), 2'($urandom)}, 3'(1 + $urandom % 6), 1'($urandom));
    $display("test bursts done");
    ctrl_u.mr(8'h01, 8'h43, 1'b0);
    ctrl_u.mr(8'h01, 8'hE3, 1'b0);
    ctrl_u.mr(8'h01, 8'h25, 1'b0);
    ctrl_u.mr(8'h03, 8'h24, 1'b0);
    wt2();
    chk({wrc, bl}, {4'h4, 5'h08});
    ctrl_u.mr(8'h01, 8'h00, 1'b1);
    chk({stb, rd}, 9'h100);
    @(posedge mclk_in);
    #1;
    chk(stb, 1'b0);
    $display("test reserved and read done");
    end_of_test();
  end
  initial
  begin
    #100000;
    err_count++;
    end_of_test();
  end
endmodule // sbmc_top_bench
bind sbmc_top sbmc_top_asserts chk_u (.mclk_in, .rst_in, .mrr_in, .burst_start_in, .col_out,
  .col_valid_out, .col_last_out, .burst_illegal_out, .read_latency_out, .write_latency_out,
  .write_recovery_cycles_out, .burst_length_out, .burst_type_out, .wrap_control_out,
  .mrr_strobe_out);
